// ===== pkg/wud_pkg.sv
`default_nettype none
package wud_pkg;
   // ---------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [5:0] IDX_CAP_CTRL = 6'h2e;
   localparam logic [5:0] IDX_CAP_RESULT = 6'h2f;
   localparam logic [5:0] IDX_AUX_STATUS = 6'h30;
   localparam logic [5:0] IDX_WAKE_CTRL = 6'h31;
   localparam logic [5:0] IDX_AMP_CFG = 6'h32;
   localparam logic [5:0] IDX_AMP_REF = 6'h33;
   localparam logic [5:0] IDX_AMP_AVG = 6'h34;
   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_REG8 = 8'h00;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CAP_TRIM_LSB = 3;
   localparam int CAP_GAIN_LSB = 0;
   localparam int WAKE_RANGE_BIT = 7;
   localparam int WAKE_CODE_LSB = 4;
   localparam int WAKE_EVERY_BIT = 3;
   localparam int WAKE_AMP_BIT = 2;
   localparam int WAKE_PHASE_BIT = 1;
   localparam int WAKE_CAPM_BIT = 0;
   localparam int AMP_THR_LSB = 4;
   localparam int AMP_INCL_BIT = 3;
   localparam int AMP_WEIGHT_LSB = 1;
   localparam int AMP_REFSEL_BIT = 0;
   localparam logic [2:0] AVG_SHIFT_BASE = 3'h2;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned TICK_MS = 10;
   localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned LONG_UNIT_MS = 100;
   localparam logic [6:0] UNITS_LONG = 7'(LONG_UNIT_MS / TICK_MS);
   localparam logic [6:0] UNITS_SHORT = 7'h01;
endpackage
`default_nettype wire

// ===== verilog/wud_wakeup_ctrl.sv
// Local design decision: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module wud_wakeup_ctrl #(
   parameter int unsigned TICK_CYCLES = wud_pkg::TICK_CYCLES
) (
   input wire logic CLK_I,
   input wire logic RSTN_I,
   input wire logic CE_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic SET_DEFAULT_I,
   input wire logic CHANNEL_PM_I,
   input wire logic FIELD_DETECT_I,
   input wire logic TX_ACTIVE_I,
   input wire logic OSC_STABLE_I,
   input wire logic RX_ENABLED_I,
   input wire logic RX_RECEIVING_I,
   input wire logic PEER_DETECT_I,
   input wire logic COLLISION_AVOID_ACTIVE_I,
   input wire logic [4:0] CAL_VALUE_I,
   input wire logic CAL_END_I,
   input wire logic CAL_ERR_I,
   output logic [4:0] CAP_TRIM_O,
   output logic CAP_AUTO_CAL_O,
   output logic [2:0] CAP_GAIN_O,
   input wire logic WAKE_ENABLE_I,
   output logic AMP_REQ_O,
   input wire logic AMP_DONE_I,
   input wire logic [7:0] AMP_RESULT_I,
   output logic PHASE_REQ_O,
   input wire logic PHASE_DONE_I,
   input wire logic PHASE_EXCEED_I,
   output logic CAPM_REQ_O,
   input wire logic CAPM_DONE_I,
   input wire logic CAPM_EXCEED_I,
   output logic WAKE_EVENT_O
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_MEAS = 2'b10
   } wud_state_e;

   typedef struct packed {
      wud_state_e state;
      logic [7:0] cap_ctrl;
      logic auto_cal;
      logic [7:0] wake_ctrl;
      logic [7:0] amp_cfg;
      logic [7:0] amp_ref;
      logic [7:0] amp_avg;
      logic [14:0] sync1;
      logic [14:0] sync2;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [31:0] tick_cnt;
      logic [6:0] unit_cnt;
      logic [2:0] pending;
      logic hit;
      logic amp_req;
      logic phase_req;
      logic capm_req;
      logic wake_event;
   } wud_regs_s;

   localparam wud_regs_s RESET_STATE = '{
      state: ST_IDLE,
      cap_ctrl: wud_pkg::RST_REG8,
      auto_cal: 1'b1, // Trim is zero after reset, so automatic mode
      wake_ctrl: wud_pkg::RST_REG8,
      amp_cfg: wud_pkg::RST_REG8,
      amp_ref: wud_pkg::RST_REG8,
      amp_avg: wud_pkg::RST_REG8,
      sync1: 15'h0000,
      sync2: 15'h0000,
      prdata: 32'h0000_0000,
      pready: 1'b0,
      pslverr: 1'b0,
      tick_cnt: 32'h0000_0000,
      unit_cnt: 7'h00,
      pending: 3'h0,
      hit: 1'b0,
      amp_req: 1'b0,
      phase_req: 1'b0,
      capm_req: 1'b0,
      wake_event: 1'b0
   };

   wud_regs_s r_reg;
   wud_regs_s r_next;
   logic expiry;
   logic wr_fire;
   logic amp_exceed;
   logic amp_take;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Address decode, shared by read and write paths
   function automatic logic reg_mapped(input logic [7:0] addr);
      logic [5:0] idx;
      idx = addr[7:2];
      return (addr[1:0] == 2'b00) && (idx >= wud_pkg::IDX_CAP_CTRL) && (idx <= wud_pkg::IDX_AMP_AVG);
   endfunction

   // Timer units of 10 ms in one wake period
   function automatic logic [6:0] period_units(input logic [7:0] ctrl);
      logic [6:0] n;
      n = {4'h0, ctrl[wud_pkg::WAKE_CODE_LSB +: 3]} + 7'h01;
      return ctrl[wud_pkg::WAKE_RANGE_BIT] ? 7'(n * wud_pkg::UNITS_SHORT) : 7'(n * wud_pkg::UNITS_LONG);
   endfunction

   // Register read mux
   function automatic logic [7:0] reg_read(input logic [5:0] idx, input wud_regs_s s);
      logic [7:0] v;
      v = 8'h00;
      unique case (idx)
         wud_pkg::IDX_CAP_CTRL: v = s.cap_ctrl;
         wud_pkg::IDX_CAP_RESULT: v = {s.sync2[12:8], s.sync2[13], s.sync2[14], 1'b0};
         wud_pkg::IDX_AUX_STATUS: v = s.sync2[7:0];
         wud_pkg::IDX_WAKE_CTRL: v = s.wake_ctrl;
         wud_pkg::IDX_AMP_CFG: v = s.amp_cfg;
         wud_pkg::IDX_AMP_REF: v = s.amp_ref;
         wud_pkg::IDX_AMP_AVG: v = s.amp_avg;
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   // Default command outranks a bus write landing in the same cycle
   always_comb begin
      logic [14:0] pins;
      logic [7:0] ref_val;
      logic [7:0] abs_diff;
      logic signed [8:0] delta;
      logic signed [8:0] step;
      logic [2:0] shift;
      logic [2:0] left;
      logic got_hit;
      pins = '0;
      ref_val = '0;
      abs_diff = '0;
      delta = '0;
      step = '0;
      shift = '0;
      left = '0;
      got_hit = 1'b0;
      r_next = r_reg;
      r_next.amp_req = 1'b0;
      r_next.phase_req = 1'b0;
      r_next.capm_req = 1'b0;
      r_next.wake_event = 1'b0;
      expiry = 1'b0;

      // Status pins through a two-stage synchroniser
      pins = {CAL_ERR_I, CAL_END_I, CAL_VALUE_I, CHANNEL_PM_I, FIELD_DETECT_I, TX_ACTIVE_I,
              OSC_STABLE_I, RX_ENABLED_I, RX_RECEIVING_I, PEER_DETECT_I, COLLISION_AVOID_ACTIVE_I};
      r_next.sync1 = pins;
      r_next.sync2 = r_reg.sync1;

      // Bus: answer one cycle after setup, so the access phase never waits
      wr_fire = PSEL_I && PENABLE_I && r_reg.pready && PWRITE_I && !r_reg.pslverr;
      r_next.pready = PSEL_I && !PENABLE_I;
      if (PSEL_I && !PENABLE_I) begin
         r_next.pslverr = !reg_mapped(PADDR_I);
         r_next.prdata = (PWRITE_I || !reg_mapped(PADDR_I)) ? 32'h0000_0000
                         : {24'h00_0000, reg_read(PADDR_I[7:2], r_reg)};
      end
      if (wr_fire) begin
         unique case (PADDR_I[7:2])
            wud_pkg::IDX_CAP_CTRL: r_next.cap_ctrl = PWDATA_I[7:0];
            wud_pkg::IDX_WAKE_CTRL: r_next.wake_ctrl = PWDATA_I[7:0];
            wud_pkg::IDX_AMP_CFG: r_next.amp_cfg = PWDATA_I[7:0];
            wud_pkg::IDX_AMP_REF: r_next.amp_ref = PWDATA_I[7:0];
            default: r_next.cap_ctrl = r_next.cap_ctrl;
         endcase
      end

      // Amplitude comparison against the selected reference
      ref_val = r_reg.amp_cfg[wud_pkg::AMP_REFSEL_BIT] ? r_reg.amp_avg : r_reg.amp_ref;
      abs_diff = (AMP_RESULT_I >= ref_val) ? 8'(AMP_RESULT_I - ref_val) : 8'(ref_val - AMP_RESULT_I);
      amp_exceed = abs_diff > {4'h0, r_reg.amp_cfg[wud_pkg::AMP_THR_LSB +: 4]};
      amp_take = (r_reg.state == ST_MEAS) && r_reg.pending[0] && AMP_DONE_I;

      // Running average; an event-causing sample is skipped unless included
      shift = wud_pkg::AVG_SHIFT_BASE + {1'b0, r_reg.amp_cfg[wud_pkg::AMP_WEIGHT_LSB +: 2]};
      delta = $signed({1'b0, AMP_RESULT_I}) - $signed({1'b0, r_reg.amp_avg});
      step = delta >>> shift;
      if (amp_take && (!amp_exceed || r_reg.amp_cfg[wud_pkg::AMP_INCL_BIT])) begin
         r_next.amp_avg = 8'(r_reg.amp_avg + step[7:0]);
      end

      // Wake timer and measurement sequence
      unique case (r_reg.state)
         ST_IDLE: begin
            if (!WAKE_ENABLE_I) begin
               r_next.tick_cnt = '0;
               r_next.unit_cnt = '0;
            end else if (r_reg.tick_cnt == TICK_CYCLES - 1) begin
               r_next.tick_cnt = '0;
               if (r_reg.unit_cnt + 7'h01 >= period_units(r_reg.wake_ctrl)) begin
                  expiry = 1'b1;
                  r_next.unit_cnt = '0;
               end else begin
                  r_next.unit_cnt = r_reg.unit_cnt + 7'h01;
               end
            end else begin
               r_next.tick_cnt = r_reg.tick_cnt + 32'h1;
            end
            if (expiry) begin
               r_next.amp_req = r_reg.wake_ctrl[wud_pkg::WAKE_AMP_BIT];
               r_next.phase_req = r_reg.wake_ctrl[wud_pkg::WAKE_PHASE_BIT];
               r_next.capm_req = r_reg.wake_ctrl[wud_pkg::WAKE_CAPM_BIT];
               r_next.pending = {r_reg.wake_ctrl[wud_pkg::WAKE_CAPM_BIT], r_reg.wake_ctrl[wud_pkg::WAKE_PHASE_BIT],
                                 r_reg.wake_ctrl[wud_pkg::WAKE_AMP_BIT]};
               r_next.hit = 1'b0;
               if (r_reg.wake_ctrl[2:0] == 3'h0) begin
                  r_next.wake_event = r_reg.wake_ctrl[wud_pkg::WAKE_EVERY_BIT];
               end else begin
                  r_next.state = ST_MEAS;
               end
            end
         end
         ST_MEAS: begin
            // Collect each answer; the event is decided once all are in
            left = r_reg.pending & ~{CAPM_DONE_I, PHASE_DONE_I, AMP_DONE_I};
            got_hit = r_reg.hit || (amp_take && amp_exceed)
                      || (r_reg.pending[1] && PHASE_DONE_I && PHASE_EXCEED_I)
                      || (r_reg.pending[2] && CAPM_DONE_I && CAPM_EXCEED_I);
            r_next.pending = left;
            r_next.hit = got_hit;
            if (left == 3'h0) begin
               r_next.wake_event = got_hit || r_reg.wake_ctrl[wud_pkg::WAKE_EVERY_BIT];
               r_next.state = ST_IDLE;
            end
         end
      endcase

      // Default command restores every register and restarts the timer
      if (SET_DEFAULT_I) begin
         r_next.cap_ctrl = wud_pkg::RST_REG8;
         r_next.wake_ctrl = wud_pkg::RST_REG8;
         r_next.amp_cfg = wud_pkg::RST_REG8;
         r_next.amp_ref = wud_pkg::RST_REG8;
         r_next.amp_avg = wud_pkg::RST_REG8;
         r_next.sync1 = 15'h0000;
         r_next.sync2 = 15'h0000;
         r_next.tick_cnt = '0;
         r_next.unit_cnt = '0;
         r_next.pending = 3'h0;
         r_next.hit = 1'b0;
         r_next.state = ST_IDLE;
      end

      // Auto flag kept in a flop so the pin carries no decode
      r_next.auto_cal = r_next.cap_ctrl[wud_pkg::CAP_TRIM_LSB +: 5] == 5'h00;
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   // Clock enable low freezes everything, bus included
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         r_reg <= RESET_STATE;
      end else if (CE_I) begin
         r_reg <= r_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // All outputs are plain register bits
   assign PRDATA_O = r_reg.prdata;
   assign PREADY_O = r_reg.pready;
   assign PSLVERR_O = r_reg.pslverr;
   assign CAP_TRIM_O = r_reg.cap_ctrl[wud_pkg::CAP_TRIM_LSB +: 5];
   assign CAP_AUTO_CAL_O = r_reg.auto_cal;
   assign CAP_GAIN_O = r_reg.cap_ctrl[wud_pkg::CAP_GAIN_LSB +: 3];
   assign AMP_REQ_O = r_reg.amp_req;
   assign PHASE_REQ_O = r_reg.phase_req;
   assign CAPM_REQ_O = r_reg.capm_req;
   assign WAKE_EVENT_O = r_reg.wake_event;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   // Frozen cycles are excluded; the checks speak of enabled edges only
   auto_cal_a: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I || !CE_I)
      (wr_fire && PADDR_I[7:2] == wud_pkg::IDX_CAP_CTRL && !SET_DEFAULT_I)
      |=> (CAP_AUTO_CAL_O == ($past(PWDATA_I[7:3]) == 5'h00)))
      else $error("auto calibration flag does not follow trim write");

   trim_gain_a: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I || !CE_I)
      (wr_fire && PADDR_I[7:2] == wud_pkg::IDX_CAP_CTRL && !SET_DEFAULT_I)
      |=> (CAP_TRIM_O == $past(PWDATA_I[7:3])) && (CAP_GAIN_O == $past(PWDATA_I[2:0])))
      else $error("trim or gain output differs from written value");

   default_clear_a: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I || !CE_I)
      SET_DEFAULT_I |=> (r_reg.wake_ctrl == 8'h00) && (r_reg.amp_cfg == 8'h00) && (r_reg.amp_avg == 8'h00))
      else $error("default command left a register set");

   field_sync_a: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I || !CE_I)
      (FIELD_DETECT_I && !SET_DEFAULT_I) [*3] |=> r_reg.sync2[6])
      else $error("field detect status not shown after synchroniser");

   period_end_a: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I || !CE_I)
      expiry |-> (r_reg.tick_cnt == TICK_CYCLES - 1) && (r_reg.unit_cnt + 7'h01 >= period_units(r_reg.wake_ctrl)))
      else $error("wake timer expired at the wrong count");

   every_event_a: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I || !CE_I)
      (expiry && !SET_DEFAULT_I && r_reg.wake_ctrl[3:0] == 4'h8) |=> WAKE_EVENT_O)
      else $error("no event on expiry with event-every-timeout set");

   meas_req_a: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I || !CE_I)
      expiry |=> (AMP_REQ_O == $past(r_reg.wake_ctrl[2])) && (PHASE_REQ_O == $past(r_reg.wake_ctrl[1]))
                 && (CAPM_REQ_O == $past(r_reg.wake_ctrl[0])))
      else $error("measurement requests do not match enables");

   amp_event_a: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I || !CE_I)
      (amp_take && amp_exceed && r_reg.pending == 3'h1 && !SET_DEFAULT_I) |=> WAKE_EVENT_O)
      else $error("amplitude excess did not raise the event");

   avg_hold_a: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I || !CE_I)
      (amp_take && amp_exceed && !r_reg.amp_cfg[3] && !SET_DEFAULT_I) |=> $stable(r_reg.amp_avg))
      else $error("excluded sample changed the average");

   bus_ready_a: assert property (
      @(posedge CLK_I) disable iff (!RSTN_I || !CE_I)
      (PSEL_I && !PENABLE_I) |=> PREADY_O ##1 !PREADY_O || (PSEL_I && !PENABLE_I))
      else $error("bus answer not given in the access cycle");
endmodule
`default_nettype wire

// ===== sim/wud_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// -----------------------------------------------------------------
// Host controller model: APB master toward the register bank
// -----------------------------------------------------------------
module wud_host_model (
   input wire logic clk_i,
   output logic psel_o,
   output logic penable_o,
   output logic pwrite_o,
   output logic [7:0] paddr_o,
   output logic [31:0] pwdata_o,
   input wire logic [31:0] prdata_i,
   input wire logic pready_i,
   input wire logic pslverr_i
);
   // Bus idle from time zero
   initial begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = 8'h00;
      pwdata_o = 32'h0000_0000;
   end

   // One transfer; an idle edge first so no signal is assigned twice in a step
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata, output logic err);
      @(posedge clk_i);
      psel_o <= 1'b1;
      penable_o <= 1'b0;
      pwrite_o <= wr;
      paddr_o <= addr;
      pwdata_o <= wdata;
      @(posedge clk_i);
      penable_o <= 1'b1;
      // Request held until ready is seen at a rising edge; only the bench watchdog ends a hang
      do begin
         @(posedge clk_i);
      end while (pready_i !== 1'b1);
      rdata = prdata_i;
      err = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== sim/wakeup_detect_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
module wakeup_detect_control_tb;
   // Short tick keeps wake periods to a few dozen cycles
   localparam int TCK = 4;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic set_def = 1'b0;
   logic [7:0] stat = 8'h00;
   logic [4:0] cal_val = 5'h00;
   logic cal_end = 1'b0;
   logic cal_err = 1'b0;
   logic wake_en = 1'b0;
   logic amp_done = 1'b0;
   logic [7:0] amp_res = 8'h00;
   logic ph_done = 1'b0, ph_exc = 1'b0, cm_done = 1'b0, cm_exc = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, auto_cal, amp_req, ph_req, cm_req, wake_ev, err, ev;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [4:0] trim;
   logic [2:0] gain;
   int miscompares = 0;
   int checked = 0;
   int n;

   // -----------------------------------------------------------------
   // Clock, parts
   // -----------------------------------------------------------------
   initial begin
      forever #12.5 clk = ~clk;
   end

   wud_host_model i_host (.clk_i(clk), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
      .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));

   wud_wakeup_ctrl #(.TICK_CYCLES(TCK)) i_dut (.CLK_I(clk), .RSTN_I(rstn), .CE_I(ce),
      .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .SET_DEFAULT_I(set_def),
      .CHANNEL_PM_I(stat[7]), .FIELD_DETECT_I(stat[6]), .TX_ACTIVE_I(stat[5]), .OSC_STABLE_I(stat[4]),
      .RX_ENABLED_I(stat[3]), .RX_RECEIVING_I(stat[2]), .PEER_DETECT_I(stat[1]),
      .COLLISION_AVOID_ACTIVE_I(stat[0]), .CAL_VALUE_I(cal_val), .CAL_END_I(cal_end),
      .CAL_ERR_I(cal_err), .CAP_TRIM_O(trim), .CAP_AUTO_CAL_O(auto_cal), .CAP_GAIN_O(gain),
      .WAKE_ENABLE_I(wake_en), .AMP_REQ_O(amp_req), .AMP_DONE_I(amp_done), .AMP_RESULT_I(amp_res),
      .PHASE_REQ_O(ph_req), .PHASE_DONE_I(ph_done), .PHASE_EXCEED_I(ph_exc), .CAPM_REQ_O(cm_req),
      .CAPM_DONE_I(cm_done), .CAPM_EXCEED_I(cm_exc), .WAKE_EVENT_O(wake_ev));

   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      i_host.xfer(1'b1, {idx, 2'b00}, {24'h000000, d}, rd, err);
   endtask

   task automatic rdc(input logic [5:0] idx, input logic [7:0] exp);
      i_host.xfer(1'b0, {idx, 2'b00}, 32'h0000_0000, rd, err);
      check(rd, {24'h000000, exp});
   endtask

   // Timer runs only in this task and in period, so a late register read cannot miss a request
   task automatic meas(input logic [2:0] which, input logic [7:0] res, input logic [1:0] exc,
                       input logic exp_ev);
      n = 0;
      wake_en <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while ((amp_req | ph_req | cm_req) !== 1'b1 && n < 400);
      check({amp_req, ph_req, cm_req}, which);
      wake_en <= 1'b0;
      amp_done <= which[2];
      amp_res <= res;
      ph_done <= which[1];
      ph_exc <= exc[1];
      cm_done <= which[0];
      cm_exc <= exc[0];
      @(posedge clk);
      {amp_done, ph_done, cm_done} <= 3'h0;
      ev = 1'b0;
      repeat (2) begin
         @(posedge clk);
         ev = ev | wake_ev;
      end
      check(ev, exp_ev);
   endtask

   // A count one cycle short or up to three cycles over is allowed for; a unit off is not
   task automatic period(input logic [7:0] ctl, input int p);
      wr(wud_pkg::IDX_WAKE_CTRL, ctl);
      n = 0;
      wake_en <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (wake_ev !== 1'b1 && n < 2000);
      wake_en <= 1'b0;
      check(32'(n >= p - 1 && n <= p + 3), 32'h1);
   endtask

   task automatic give_verdict();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Cut a hang short well past the expected run
   initial begin
      #2000000;
      miscompares++;
      give_verdict();
   end

   // -----------------------------------------------------------------
   // Test sequence
   // -----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 7; i++) rdc(wud_pkg::IDX_CAP_CTRL + 6'(i), 8'h00);
      wr(wud_pkg::IDX_CAP_CTRL, 8'hf9);
      @(posedge clk);
      check({trim, auto_cal, gain}, {5'h1f, 1'b0, 3'h1});
      rdc(wud_pkg::IDX_CAP_CTRL, 8'hf9);
      for (int g = 0; g < 7; g += (g < 2) ? 1 : 2) begin
         wr(wud_pkg::IDX_CAP_CTRL, {5'h00, 3'(g)});
         @(posedge clk);
         check({trim, auto_cal, gain}, {5'h00, 1'b1, 3'(g)});
      end
      // Clock enable low: a default pulse in a frozen cycle must not land
      ce <= 1'b0;
      set_def <= 1'b1;
      @(posedge clk);
      {ce, set_def} <= 2'b10;
      rdc(wud_pkg::IDX_CAP_CTRL, 8'h06);
      // Unmapped word is refused with an error
      i_host.xfer(1'b1, 8'hd4, 32'h0000_00ff, rd, err);
      check(err, 1'b1);
      wr(wud_pkg::IDX_AMP_AVG, 8'h5a);
      rdc(wud_pkg::IDX_AMP_AVG, 8'h00);
      wr(wud_pkg::IDX_AMP_REF, 8'ha5);
      rdc(wud_pkg::IDX_AMP_REF, 8'ha5);
      for (int i = 0; i < 8; i++) begin
         stat <= 8'h01 << i;
         repeat (4) @(posedge clk);
         rdc(wud_pkg::IDX_AUX_STATUS, 8'h01 << i);
      end
      {cal_val, cal_end, cal_err} <= {5'h15, 1'b1, 1'b1};
      repeat (4) @(posedge clk);
      rdc(wud_pkg::IDX_CAP_RESULT, 8'hae);
      wr(wud_pkg::IDX_WAKE_CTRL, 8'h7f);
      wr(wud_pkg::IDX_AMP_CFG, 8'hff);
      {stat, cal_val, cal_end, cal_err} <= 15'h0000;
      repeat (4) @(posedge clk);
      set_def <= 1'b1;
      @(posedge clk);
      set_def <= 1'b0;
      for (int i = 0; i < 7; i++) rdc(wud_pkg::IDX_CAP_CTRL + 6'(i), 8'h00);
      period(8'h08, 10 * TCK);
      period(8'hf8, 8 * TCK);
      // Amplitude: threshold 3, stored reference, weight 4, excess excluded
      wr(wud_pkg::IDX_WAKE_CTRL, 8'h84);
      wr(wud_pkg::IDX_AMP_REF, 8'h40);
      wr(wud_pkg::IDX_AMP_CFG, 8'h30);
      meas(3'b100, 8'h44, 2'b00, 1'b1);
      rdc(wud_pkg::IDX_AMP_AVG, 8'h00);
      meas(3'b100, 8'h43, 2'b00, 1'b0);
      rdc(wud_pkg::IDX_AMP_AVG, 8'h10);
      // Average as reference, weight 32, excess included
      wr(wud_pkg::IDX_AMP_CFG, 8'h3f);
      meas(3'b100, 8'h12, 2'b00, 1'b0);
      meas(3'b100, 8'h30, 2'b00, 1'b1);
      rdc(wud_pkg::IDX_AMP_AVG, 8'h11);
      // Weights 8 and 16 on the stored reference; the last step is negative
      wr(wud_pkg::IDX_AMP_CFG, 8'h3a);
      meas(3'b100, 8'h51, 2'b00, 1'b1);
      rdc(wud_pkg::IDX_AMP_AVG, 8'h19);
      wr(wud_pkg::IDX_AMP_CFG, 8'h3c);
      meas(3'b100, 8'h3f, 2'b00, 1'b0);
      meas(3'b100, 8'h09, 2'b00, 1'b1);
      rdc(wud_pkg::IDX_AMP_AVG, 8'h19);
      wr(wud_pkg::IDX_WAKE_CTRL, 8'h83);
      meas(3'b011, 8'h00, 2'b01, 1'b1);
      meas(3'b011, 8'h00, 2'b00, 1'b0);
      meas(3'b011, 8'h00, 2'b10, 1'b1);
      // Event on every timeout even when the measurement shows no excess
      wr(wud_pkg::IDX_WAKE_CTRL, 8'h89);
      meas(3'b001, 8'h00, 2'b00, 1'b1);
      give_verdict();
   end
endmodule
`default_nettype wire
